//--- hdl/rod_vote_pkg.sv
// Shared constants and types for the rod insertion voting ends
package rod_vote_pkg;

    // ------------------------------------------------------------
    // Redundancy shape
    // ------------------------------------------------------------
    localparam int FLOW_CHANNELS  = 3;
    localparam int NM_DIVISIONS   = 4;
    localparam int NM_ALARMS      = 10;
    localparam int SCRAM_DIVS     = 2;
    localparam int VOTED_FUNCS    = 3;
    localparam int MANUAL_FUNCS   = 2;
    localparam int LEVEL_W        = 10;
    localparam int PUMP_CNT_W     = 4;

    // Indices of voted request groups
    localparam int FN_AFI         = 0;
    localparam int FN_BLOCK       = 1;
    localparam int FN_RUNIN       = 2;

    // Indices of two-action manual functions
    localparam int MAN_AFI        = 0;
    localparam int MAN_RUNIN      = 1;

    // ------------------------------------------------------------
    // Plant thresholds, in tenths of a percent of rated
    // ------------------------------------------------------------
    localparam logic [LEVEL_W-1:0]    FLOW_LOW_PM     = 10'h168;  // 36.0 %
    localparam logic [LEVEL_W-1:0]    PWR_BLOCK_PM    = 10'h0FA;  // 25.0 %
    localparam logic [LEVEL_W-1:0]    PWR_RUNIN_PM    = 10'h12C;  // 30.0 %
    localparam logic [PUMP_CNT_W-1:0] PUMPS_TRIP_MIN  = 4'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 10_000_000;
    localparam int RUNIN_BUDGET_MS = 2000;
    localparam int RUNIN_BUDGET_CYC = RUNIN_BUDGET_MS * (CLK_HZ / 1000);

    // ------------------------------------------------------------
    // Reactor mode switch and alarm qualification masks
    // Alarm bits: 0 period, 1 src down, 2 src up, 3 pwr up, 4 src inop,
    // 5 pwr down, 6 flow-biased, 7 pwr inop, 8 permissive, 9 flow up
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SHUTDOWN = 2'b00,
        MODE_REFUEL   = 2'b01,
        MODE_STARTUP  = 2'b10,
        MODE_RUN      = 2'b11
    } mode_e;

    localparam logic [NM_ALARMS-1:0] MASK_SHUTDOWN = 10'h000;
    localparam logic [NM_ALARMS-1:0] MASK_REFUEL   = 10'h017;
    localparam logic [NM_ALARMS-1:0] MASK_STARTUP  = 10'h09D;
    localparam logic [NM_ALARMS-1:0] MASK_RUN      = 10'h2E8;

    // Run-in start watchdog states
    typedef enum logic [1:0] {
        WD_IDLE   = 2'b00,
        WD_WAIT   = 2'b01,
        WD_MOVING = 2'b10,
        WD_LATE   = 2'b11
    } watch_e;

    localparam logic [24:0] CNT_ZERO = 25'h000_0000;
    localparam logic [24:0] CNT_ONE  = 25'h000_0001;

endpackage : rod_vote_pkg

//--- hdl/plant_link_if.sv
// Discrete signal link between the flow controller and one rod control channel
`timescale 1ns/100ps
interface plant_link_if;
    import rod_vote_pkg::*;

    logic [FLOW_CHANNELS-1:0] afi_req;        // One bit per flow channel
    logic [FLOW_CHANNELS-1:0] block_req;      // Rod block set
    logic [FLOW_CHANNELS-1:0] runin_req;      // Selected rod run-in set
    logic                     flow_inc_block; // Back toward flow controller

    modport rod_end (
        input  afi_req,
        input  block_req,
        input  runin_req,
        output flow_inc_block
    );

    modport flow_end (
        output afi_req,
        output block_req,
        output runin_req,
        input  flow_inc_block
    );

endinterface : plant_link_if

//--- hdl/vote_2oo3.sv
// Two-out-of-three majority voter
`timescale 1ns/100ps
module vote_2oo3 (
    input  wire logic [2:0] votes,
    output wire logic       hit
);
    // Any two of three agree
    assign hit = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]);
endmodule : vote_2oo3

//--- hdl/rod_control_end.sv
// One rod control channel: voting, two-action manual starts, block logic
// Functional notes
// - Vote three insertion requests, then drive all in
// - Manual full insertion needs two operator actions
// - Manual run-in needs two operator actions
// - Flow channels vote heating loss, send run-in
// - Pumps tripped, low flow, mid power: rod block
// - Pumps tripped, low flow, high power: run-in
// - Flow side requests suppressed outside setpoints
// - Vote block and run-in sets two of three
// - Each channel acts alone on flow signals
// - Pump trip to rod motion within two seconds
// - Thermal monitor trip blocks flow increase
// - Scram indication follows any scram division, with no hold
// - Mode switch qualifies neutron monitor rod blocks
`timescale 1ns/100ps
module rod_control_end
    import rod_vote_pkg::*;
#(
    parameter int BUDGET_CYC = RUNIN_BUDGET_CYC
) (
    input  wire logic                              clk,
    input  wire logic                              nrst,
    plant_link_if.rod_end                          link,
    input  wire logic [MANUAL_FUNCS-1:0]           man_arm,
    input  wire logic [MANUAL_FUNCS-1:0]           man_go,
    input  wire logic                              op_reset,
    input  wire logic                              thermal_trip,
    input  wire logic [NM_DIVISIONS*NM_ALARMS-1:0] nm_alarm,
    input  wire logic [1:0]                        mode_sw,
    input  wire logic [SCRAM_DIVS-1:0]             scram_div,
    input  wire logic                              motion_started,
    output logic                                   alternate_full_insertion,
    output logic                                   selected_rod_runin,
    output logic                                   rod_block,
    output logic                                   scram_follow,
    output logic                                   runin_overdue
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [VOTED_FUNCS-1:0]  vote_hit;
    logic [2:0]              vote_in [VOTED_FUNCS];
    logic [MANUAL_FUNCS-1:0] go_prev_q;
    logic [MANUAL_FUNCS-1:0] man_fire;
    logic                    afi_q;
    logic                    afi_d;
    logic                    runin_q;
    logic                    runin_d;
    logic                    block_q;
    logic                    block_d;
    logic                    flow_blk_q;
    logic                    scram_q;
    logic                    late_q;
    logic [NM_ALARMS-1:0]    nm_any;
    logic [NM_ALARMS-1:0]    mode_mask;
    logic                    nm_block;
    logic                    start_afi;
    logic                    start_runin;
    logic                    budget_hit;
    logic [24:0]             wd_cnt_q;
    logic [24:0]             wd_cnt_d;
    watch_e                  wd_q;
    watch_e                  wd_d;
    mode_e                   mode;

    // ------------------------------------------------------------
    // Majority voting of flow controller request sets
    // ------------------------------------------------------------
    assign vote_in[FN_AFI]   = link.afi_req;
    assign vote_in[FN_BLOCK] = link.block_req;
    assign vote_in[FN_RUNIN] = link.runin_req;

    // One voter per request group, local to this channel
    generate
        for (genvar f = 0; f < VOTED_FUNCS; f++) begin : g_vote
            vote_2oo3 u_vote (
                .votes (vote_in[f]),
                .hit   (vote_hit[f])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Two-action manual initiation: arm held, then go pressed
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            go_prev_q <= '0;
        end else begin
            go_prev_q <= man_go;
        end
    end

    // Fires only on a new go press while arm is held in that same cycle
    assign man_fire = man_arm & man_go & ~go_prev_q;

    assign start_afi   = vote_hit[FN_AFI] | man_fire[MAN_AFI];
    assign start_runin = vote_hit[FN_RUNIN] | man_fire[MAN_RUNIN];

    // ------------------------------------------------------------
    // Neutron monitor alarm qualification by mode switch
    // ------------------------------------------------------------
    assign mode = mode_e'(mode_sw);

    // Any division raising an alarm counts for that alarm
    generate
        for (genvar a = 0; a < NM_ALARMS; a++) begin : g_alarm
            logic [NM_DIVISIONS-1:0] per_div;
            for (genvar d = 0; d < NM_DIVISIONS; d++) begin : g_div
                assign per_div[d] = nm_alarm[d*NM_ALARMS + a];
            end
            assign nm_any[a] = |per_div;
        end
    endgenerate

    // Mask table selected by the current mode position
    assign mode_mask = (mode == MODE_SHUTDOWN) ? MASK_SHUTDOWN :
                       (mode == MODE_REFUEL)   ? MASK_REFUEL   :
                       (mode == MODE_STARTUP)  ? MASK_STARTUP  :
                                                 MASK_RUN;
    assign nm_block  = |(nm_any & mode_mask);

    // ------------------------------------------------------------
    // Sealed-in functions; a new start wins over operator reset
    // ------------------------------------------------------------
    assign afi_d   = start_afi | (afi_q & ~op_reset);
    assign runin_d = start_runin | (runin_q & ~op_reset);

    // Rod block follows its sources with no seal-in
    assign block_d = vote_hit[FN_BLOCK] | nm_block | thermal_trip;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            afi_q   <= 1'b0;
            runin_q <= 1'b0;
            block_q <= 1'b0;
        end else begin
            afi_q   <= afi_d;
            runin_q <= runin_d;
            block_q <= block_d;
        end
    end

    // ------------------------------------------------------------
    // Flow increase block and scram following
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flow_blk_q <= 1'b0;
            scram_q    <= 1'b0;
        end else begin
            flow_blk_q <= thermal_trip;
            scram_q    <= |scram_div;
        end
    end

    assign link.flow_inc_block = flow_blk_q;

    // ------------------------------------------------------------
    // Run-in start watchdog: the whole run-in budget by default, counted from seal-in
    // ------------------------------------------------------------
    assign budget_hit = (wd_cnt_q >= 25'(BUDGET_CYC - 1));

    always_comb begin
        wd_d     = wd_q;
        wd_cnt_d = wd_cnt_q;
        unique case (wd_q)
            WD_IDLE: begin
                wd_cnt_d = CNT_ZERO;
                if (runin_q) begin
                    wd_d = WD_WAIT;
                end
            end
            WD_WAIT: begin
                wd_cnt_d = wd_cnt_q + CNT_ONE;
                if (!runin_q) begin
                    wd_d = WD_IDLE;
                end else if (motion_started) begin
                    wd_d = WD_MOVING;
                end else if (budget_hit) begin
                    wd_d = WD_LATE;
                end
            end
            WD_MOVING: begin
                if (!runin_q) begin
                    wd_d = WD_IDLE;
                end
            end
            WD_LATE: begin
                if (!runin_q) begin
                    wd_d = WD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wd_q     <= WD_IDLE;
            wd_cnt_q <= CNT_ZERO;
            late_q   <= 1'b0;
        end else begin
            wd_q     <= wd_d;
            wd_cnt_q <= wd_cnt_d;
            late_q   <= (wd_d == WD_LATE);
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign alternate_full_insertion = afi_q;
    assign selected_rod_runin       = runin_q;
    assign rod_block                = block_q;
    assign scram_follow             = scram_q;
    assign runin_overdue            = late_q;

endmodule : rod_control_end

//--- hdl/flow_control_end.sv
// Triply redundant flow controller end feeding both rod control channels
`timescale 1ns/100ps
module flow_control_end
    import rod_vote_pkg::*;
(
    input  wire logic                                clk,
    input  wire logic                                nrst,
    plant_link_if.flow_end                           link_a,
    plant_link_if.flow_end                           link_b,
    input  wire logic [FLOW_CHANNELS-1:0]            transient_trip,
    input  wire logic [FLOW_CHANNELS*3-1:0]          fw_heat_loss,
    input  wire logic [FLOW_CHANNELS*PUMP_CNT_W-1:0] pumps_tripped,
    input  wire logic [FLOW_CHANNELS*LEVEL_W-1:0]    core_flow,
    input  wire logic [FLOW_CHANNELS*LEVEL_W-1:0]    power_level,
    output logic                                     flow_raise_inhibit
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [FLOW_CHANNELS-1:0] afi_q;
    logic [FLOW_CHANNELS-1:0] block_q;
    logic [FLOW_CHANNELS-1:0] runin_q;
    logic [FLOW_CHANNELS-1:0] block_d;
    logic [FLOW_CHANNELS-1:0] runin_d;
    logic                     inhibit_q;

    // ------------------------------------------------------------
    // Per-channel request logic
    // ------------------------------------------------------------
    generate
        for (genvar c = 0; c < FLOW_CHANNELS; c++) begin : g_chan
            logic                  fw_vote;
            logic                  pumps_low;
            logic                  flow_low;
            logic [LEVEL_W-1:0]    pwr;
            logic [PUMP_CNT_W-1:0] npump;

            assign pwr   = power_level[c*LEVEL_W +: LEVEL_W];
            assign npump = pumps_tripped[c*PUMP_CNT_W +: PUMP_CNT_W];

            // Heating loss requests from the feedwater controller
            vote_2oo3 u_fw (
                .votes (fw_heat_loss[c*3 +: 3]),
                .hit   (fw_vote)
            );

            assign pumps_low = (npump >= PUMPS_TRIP_MIN);
            assign flow_low  = (core_flow[c*LEVEL_W +: LEVEL_W] < FLOW_LOW_PM);

            // Mid power band gives block, high power gives run-in
            assign block_d[c] = pumps_low & flow_low & (pwr > PWR_BLOCK_PM)
                                & (pwr < PWR_RUNIN_PM);
            assign runin_d[c] = fw_vote
                                | (pumps_low & flow_low & (pwr >= PWR_RUNIN_PM));
        end
    endgenerate

    // One register stage keeps the pump trip path short
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            afi_q     <= '0;
            block_q   <= '0;
            runin_q   <= '0;
            inhibit_q <= 1'b0;
        end else begin
            afi_q     <= transient_trip;
            block_q   <= block_d;
            runin_q   <= runin_d;
            inhibit_q <= link_a.flow_inc_block | link_b.flow_inc_block;
        end
    end

    // ------------------------------------------------------------
    // Same requests to both rod control channels
    // ------------------------------------------------------------
    assign link_a.afi_req   = afi_q;
    assign link_a.block_req = block_q;
    assign link_a.runin_req = runin_q;
    assign link_b.afi_req   = afi_q;
    assign link_b.block_req = block_q;
    assign link_b.runin_req = runin_q;
    assign flow_raise_inhibit = inhibit_q;

endmodule : flow_control_end

//--- tb/rod_link_monitor.sv
// Assertions on the link between the flow end and rod control channel a
`timescale 1ns/100ps
module rod_link_monitor
    import rod_vote_pkg::*;
(
    input wire logic                     clk,
    input wire logic                     nrst,
    input wire logic [FLOW_CHANNELS-1:0] afi_req,
    input wire logic [FLOW_CHANNELS-1:0] block_req,
    input wire logic [FLOW_CHANNELS-1:0] runin_req,
    input wire logic                     flow_inc_block,
    input wire logic                     thermal_trip,
    input wire logic [MANUAL_FUNCS-1:0]  man_arm,
    input wire logic [MANUAL_FUNCS-1:0]  man_go,
    input wire logic                     alternate_full_insertion,
    input wire logic                     selected_rod_runin,
    input wire logic                     rod_block
);
    // ----------------------------------------
    // Voting, manual starts and thermal block
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    vote_afi_a: assert property ($countones(afi_req) >= 2 |=> alternate_full_insertion)
        else $error("full insertion missed after majority request");
    quiet_afi_a: assert property (!alternate_full_insertion && $countones(afi_req) < 2
        && !(man_arm[0] && man_go[0]) |=> !alternate_full_insertion)
        else $error("full insertion started without majority or two actions");
    manual_afi_a: assert property (man_arm[0] && $rose(man_go[0])
        |=> alternate_full_insertion)
        else $error("full insertion missed after two operator actions");
    vote_runin_a: assert property ($countones(runin_req) >= 2 |=> selected_rod_runin)
        else $error("run-in missed after majority request");
    quiet_runin_a: assert property (!selected_rod_runin && $countones(runin_req) < 2
        && !(man_arm[1] && man_go[1]) |=> !selected_rod_runin)
        else $error("run-in started without majority or two actions");
    manual_runin_a: assert property (man_arm[1] && $rose(man_go[1])
        |=> selected_rod_runin)
        else $error("run-in missed after two operator actions");
    vote_block_a: assert property ($countones(block_req) >= 2 |=> rod_block)
        else $error("rod block missed after majority request");
    heat_block_a: assert property (thermal_trip |=> rod_block && flow_inc_block)
        else $error("thermal trip did not block rods and flow increase");
    inc_follow_a: assert property (!thermal_trip |=> !flow_inc_block)
        else $error("flow increase block without thermal trip");

    // Main scenarios reached
    cover property ($countones(afi_req) >= 2);
    cover property (man_arm[1] && $rose(man_go[1]));
    cover property ($countones(block_req) >= 2);
endmodule : rod_link_monitor

//--- tb/tb.sv
// Bench joining the flow end to two rod control channels
`timescale 1ns/100ps
module tb;
    import rod_vote_pkg::*;

    // ----------------------------------------
    // Signals, expectations and bookkeeping
    // ----------------------------------------
    localparam int BUDGET = 20;
    localparam int LIMIT  = 3000;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [2:0]  trip = 3'h0;
    logic [8:0]  fw = 9'h000;
    logic [11:0] pumps = 12'h000;
    logic [29:0] flow = {3{10'h3e8}};
    logic [29:0] pwr = {3{10'h3e8}};
    logic [1:0]  arm [2] = '{2'h0, 2'h0};
    logic [1:0]  go [2] = '{2'h0, 2'h0};
    logic [1:0]  opr = 2'h0, therm = 2'h0, mode = 2'h0, scram = 2'h0;
    logic [39:0] nm = '0;
    logic        motion = 1'b0;
    logic [31:0] rnd = 32'hbd75_d6fd;
    logic [1:0]  e_afi = 2'h0, e_sri = 2'h0, e_blk = 2'h0, e_scr = 2'h0, e_late = 2'h0;
    logic [1:0]  e_inc = 2'h0;
    logic        e_raise = 1'b0, hit;
    logic [2:0]  msk;
    logic [9:0]  mk;
    logic [12:0] want;
    logic [12:0] notes [$];
    int          error_cnt = 0, n_compared = 0, cyc = 0, r;
    event        look;
    wire  [1:0]  afi, sri, blk, scr, late, inc;
    wire         raise;
    wire  [12:0] obs = {afi, sri, blk, scr, late, inc, raise};
    // Pump count, flow, power per row
    logic [9:0]  tbl [8][3] = '{'{10'h002, 10'h167, 10'h0fb}, '{10'h002, 10'h168, 10'h0fb},
        '{10'h001, 10'h12c, 10'h104}, '{10'h002, 10'h12c, 10'h0fa}, '{10'h002, 10'h12c, 10'h12b},
        '{10'h002, 10'h12c, 10'h12c}, '{10'h003, 10'h000, 10'h136}, '{10'h002, 10'h169, 10'h136}};

    plant_link_if link [2] ();

    flow_control_end i_flow_control_end (
        .clk(clk), .nrst(nrst), .link_a(link[0]), .link_b(link[1]), .transient_trip(trip),
        .fw_heat_loss(fw), .pumps_tripped(pumps), .core_flow(flow), .power_level(pwr),
        .flow_raise_inhibit(raise)
    );

    // Two rod channels, each on its own link
    for (genvar i = 0; i < 2; i++) begin : g_end
        rod_control_end #(.BUDGET_CYC(BUDGET)) i_rod_control_end (
            .clk(clk), .nrst(nrst), .link(link[i]), .man_arm(arm[i]), .man_go(go[i]),
            .op_reset(opr[i]), .thermal_trip(therm[i]), .nm_alarm(nm), .mode_sw(mode),
            .scram_div(scram), .motion_started(motion), .alternate_full_insertion(afi[i]),
            .selected_rod_runin(sri[i]), .rod_block(blk[i]), .scram_follow(scr[i]),
            .runin_overdue(late[i])
        );
        assign inc[i] = link[i].flow_inc_block;
    end

    rod_link_monitor i_rod_link_monitor (
        .clk(clk), .nrst(nrst), .afi_req(link[0].afi_req), .block_req(link[0].block_req),
        .runin_req(link[0].runin_req), .flow_inc_block(link[0].flow_inc_block),
        .thermal_trip(therm[0]), .man_arm(arm[0]), .man_go(go[0]),
        .alternate_full_insertion(afi[0]), .selected_rod_runin(sri[0]), .rod_block(blk[0])
    );

    always #50 clk = ~clk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic maj(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : maj

    task automatic step;
        @(posedge clk);
        #2;
    endtask : step

    // Outputs are settled levels three edges after a change
    task automatic check;
        repeat (3) @(posedge clk);
        #10;
        notes.push_back({e_afi, e_sri, e_blk, e_scr, e_late, e_inc, e_raise});
        -> look;
    endtask : check

    task automatic clr;
        step;
        opr = 2'h3;
        step;
        opr = 2'h0;
        {e_afi, e_sri, e_blk, e_late} = 8'h00;
        check();
    endtask : clr

    // Unselected channels sit at normal plant values
    task automatic plant(input logic [2:0] m, input logic [9:0] p, f, w);
        for (int c = 0; c < 3; c++) begin
            pumps[c*4 +: 4] = m[c] ? p[3:0] : 4'h0;
            flow[c*10 +: 10] = m[c] ? f : 10'h3e8;
            pwr[c*10 +: 10] = m[c] ? w : 10'h3e8;
        end
    endtask : plant

    task automatic close_out;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    // Compare each observation with the oldest note
    always begin
        @(look);
        want = notes.pop_front();
        n_compared++;
        if (obs !== want) begin
            error_cnt++;
            $display("[FAIL] %0t: outputs %h expected %h", $time, obs, want);
        end
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            close_out();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        #2;
        nrst = 1'b1;
        check();
        for (int m = 0; m < 8; m++) begin
            step;
            trip = m[2:0];
            e_afi = {2{maj(m[2:0])}};
            check();
            step;
            trip = 3'h0;
            clr();
        end
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            r = i % 8;
            msk = 3'h1 << (rnd % 3);
            if (i < 8) msk = ~msk | {3{rnd[3]}};
            step;
            plant(msk, tbl[r][0], tbl[r][1], tbl[r][2]);
            hit = maj(msk) && tbl[r][0] >= PUMPS_TRIP_MIN && tbl[r][1] < FLOW_LOW_PM;
            e_blk = {2{hit && tbl[r][2] > PWR_BLOCK_PM && tbl[r][2] < PWR_RUNIN_PM}};
            e_sri = {2{hit && tbl[r][2] >= PWR_RUNIN_PM}};
            check();
            step;
            plant(3'h0, 10'h000, 10'h000, 10'h000);
            clr();
        end
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            step;
            fw = rnd[8:0];
            e_sri = {2{maj({maj(fw[8:6]), maj(fw[5:3]), maj(fw[2:0])})}};
            check();
            step;
            fw = 9'h000;
            clr();
        end
        for (int f = 0; f < 2; f++) begin
            step;
            go[0][f] = 1'b1;
            check();
            step;
            arm[0][f] = 1'b1;
            check();
            step;
            go[0][f] = 1'b0;
            step;
            go[0][f] = 1'b1;
            e_afi[0] = (f == 0);
            e_sri[0] = (f == 1);
            check();
            step;
            {arm[0][f], go[0][f]} = 2'h0;
            clr();
        end
        for (int t = 1; t < 4; t++) begin
            step;
            therm = t[1:0];
            {e_blk, e_inc, e_raise} = {therm, therm, 1'b1};
            check();
        end
        for (int m = 0; m < 4; m++) begin
            for (int a = 0; a < 10; a++) begin
                rnd = lfsr(rnd);
                step;
                {therm, mode, nm} = {2'h0, m[1:0], 40'h00_0000_0000};
                nm[(rnd % 4) * 10 + a] = 1'b1;
                mk = m == 0 ? MASK_SHUTDOWN : m == 1 ? MASK_REFUEL :
                     m == 2 ? MASK_STARTUP : MASK_RUN;
                {e_blk, e_inc, e_raise} = {{2{mk[a]}}, 3'h0};
                check();
            end
        end
        step;
        {nm, scram} = {40'h00_0000_0000, rnd[1:0] | 2'h1};
        {e_blk, e_scr} = 4'h3;
        check();
        step;
        scram = 2'h0;
        e_scr = 2'h0;
        check();
        for (int k = 0; k < 2; k++) begin
            step;
            motion = k[0];
            plant(3'h7, 10'h003, 10'h000, 10'h136);
            e_sri = 2'h3;
            check();
            repeat (25) @(posedge clk);
            e_late = {2{k == 0}};
            check();
            step;
            plant(3'h0, 10'h000, 10'h000, 10'h000);
            motion = 1'b0;
            clr();
        end
        close_out();
    end
endmodule : tb
